// [rtl/pgb_delay.v]
/*
 * Power-good release timer: output drops at once when the input goes
 * bad and rises only after the input stayed good for the selected time.
 * Assumes the input is already synchronised to clk_sys.
 */
`timescale 1ns/1ps
`include "pgb_map.vh"

module pgb_delay #(
	parameter CNT_W = 27,
	parameter [CNT_W-1:0] DLY0_CYC = `PGB_DLY0_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY1_CYC = `PGB_DLY1_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY2_CYC = `PGB_DLY2_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY3_CYC = `PGB_DLY3_MS * `PGB_CYC_PER_MS
) (
	input  wire       clk_sys,
	input  wire       sys_rst,
	input  wire       all_good,
	input  wire [1:0] dly_sel,
	output reg        good_q
);

	reg  [CNT_W-1:0] cnt_q;
	reg  [CNT_W-1:0] limit;

	// Delay choice; changing it mid-count takes effect on the running count
	always @* begin
		case (dly_sel)
			2'h0:    limit = DLY0_CYC;
			2'h1:    limit = DLY1_CYC;
			2'h2:    limit = DLY2_CYC;
			default: limit = DLY3_CYC;
		endcase
	end

	// Any bad cycle restarts the wait, so glitches never release the pin
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q  <= {CNT_W{1'b0}};
			good_q <= 1'b0;
		end else if (!all_good) begin
			cnt_q  <= {CNT_W{1'b0}};
			good_q <= 1'b0;
		end else if (!good_q) begin
			if (cnt_q >= limit - 1'b1) begin
				good_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

endmodule

// [rtl/pgb_map.vh]
/*
 * Register offsets, field positions, reset values, unlock key and
 * power-good delay times for the power-good control and buck-one
 * control register bank.
 * Assumes an 8-bit register interface driven by the I2C slave logic
 * on the same clock, and a 200 MHz system clock.
 */
// Operation
// - Power-good control bits 7..4 read zero, ignore writes
// - Linreg one mask clear lets its status pull pin
// - Linreg two mask clear lets its status pull pin
// - Delay field picks 20, 100, 200, 400 ms
// - Protected writes need unlock before each write
// - Key 0x7D unlocks one write; cleared after transaction
// - Only unmasked good statuses feed the pin
// - Bit 7 selects register or external voltage
// - Buck-one bit 6 reads zero, ignores writes
// - Codes up to 011000: 0.9 V plus 25 mV
// - Then 50 mV steps, 3.1, 3.2, 3.3 V top
// - Voltage code LSB is not writable
// - Buck-one control resets to 0x18
// - Power-good control resets to 0x0C
`ifndef PGB_MAP_VH
`define PGB_MAP_VH

/****************************************************************
 * Register map
 ****************************************************************/
`define PGB_ADDR_UNLOCK_KEY    8'h0b
`define PGB_ADDR_PG_CTRL       8'h0d
`define PGB_ADDR_BUCK1_CTRL    8'h0e
`define PGB_UNLOCK_VALUE       8'h7d
`define PGB_UNLOCK_RST         8'h00
`define PGB_PG_CTRL_RST        8'h0c
`define PGB_BUCK1_CTRL_RST     8'h18
`define PGB_PG_CTRL_WMASK      8'h0f
`define PGB_BUCK1_CTRL_WMASK   8'hbe

/****************************************************************
 * Field positions
 ****************************************************************/
`define PGB_PG_MASK_ONE_BIT    3
`define PGB_PG_MASK_TWO_BIT    2
`define PGB_PG_DLY_HI          1
`define PGB_PG_DLY_LO          0
`define PGB_BUCK1_EXT_BIT      7
`define PGB_BUCK1_CODE_HI      5
`define PGB_BUCK1_CODE_LO      0

/****************************************************************
 * Delay and voltage figures
 ****************************************************************/
`define PGB_CLK_MHZ            200
`define PGB_DLY0_MS            20
`define PGB_DLY1_MS            100
`define PGB_DLY2_MS            200
`define PGB_DLY3_MS            400
`define PGB_CYC_PER_MS         (`PGB_CLK_MHZ * 1000)
`define PGB_V_BASE_MV          900
`define PGB_V_FINE_STEP_MV     25
`define PGB_V_COARSE_STEP_MV   50
`define PGB_V_MID_MV           1500
`define PGB_V_FINE_LAST        6'h18
`define PGB_V_COARSE_LAST      6'h34
`define PGB_V_CODE_35          6'h35
`define PGB_V_CODE_36          6'h36
`define PGB_V_CODE_37          6'h37
`define PGB_V_CODE_35_MV       3000
`define PGB_V_CODE_36_MV       3100
`define PGB_V_CODE_37_MV       3200
`define PGB_V_TOP_MV           3300

`endif

// [rtl/pgb_regs.v]
/*
 * Password-protected power-good control and buck-one control registers,
 * plus the unlock key register and the open-drain power-good pin.
 * Assumes the I2C slave presents one-cycle read/write strobes with an
 * 8-bit address on clk_sys, and a txn_end pulse at each I2C stop.
 * Regulator status inputs come from the analog side, asynchronously.
 */
`timescale 1ns/1ps
`include "pgb_map.vh"

module pgb_regs #(
	parameter CNT_W = 27,
	parameter [CNT_W-1:0] DLY0_CYC = `PGB_DLY0_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY1_CYC = `PGB_DLY1_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY2_CYC = `PGB_DLY2_MS * `PGB_CYC_PER_MS,
	parameter [CNT_W-1:0] DLY3_CYC = `PGB_DLY3_MS * `PGB_CYC_PER_MS
) (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire [7:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	input  wire        txn_end,
	input  wire        linreg_one_good_status,
	input  wire        linreg_two_good_status,
	input  wire        other_good,
	output wire        power_good_pin_o,
	output wire        power_good_pin_oe,
	output reg         buck_one_external_adjust,
	output reg  [5:0]  buck_one_voltage_code,
	output reg  [11:0] buck_one_target_mv
);

	/****************************************************************
	 * Registers
	 ****************************************************************/
	reg  [7:0]  unlock_key_q;
	reg  [7:0]  power_good_control_q;
	reg  [7:0]  buck_one_control_q;
	reg  [2:0]  s1_q;
	reg  [2:0]  s2_q;
	reg         armed_q;
	wire        unlocked;
	wire        prot_addr;
	wire        prot_ok;
	wire        all_good;
	wire        delayed_good;
	wire [11:0] mv;

	assign unlocked  = (unlock_key_q == `PGB_UNLOCK_VALUE);
	assign prot_addr = (reg_addr == `PGB_ADDR_PG_CTRL) || (reg_addr == `PGB_ADDR_BUCK1_CTRL);
	assign prot_ok   = reg_wr && prot_addr && unlocked;

	// Key register: cleared after the transaction that follows the one
	// that wrote the key, or right after a protected write consumes it
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			unlock_key_q <= `PGB_UNLOCK_RST;
			armed_q      <= 1'b0;
		end else if (reg_wr && reg_addr == `PGB_ADDR_UNLOCK_KEY) begin
			unlock_key_q <= reg_wdata;
			armed_q      <= 1'b0;
		end else if (prot_ok) begin
			unlock_key_q <= `PGB_UNLOCK_RST;
			armed_q      <= 1'b0;
		end else if (txn_end) begin
			if (armed_q) begin
				unlock_key_q <= `PGB_UNLOCK_RST;
			end
			armed_q <= (unlock_key_q != `PGB_UNLOCK_RST) && !armed_q;
		end
	end

	// Protected registers; locked writes are dropped silently
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			power_good_control_q <= `PGB_PG_CTRL_RST;
			buck_one_control_q   <= `PGB_BUCK1_CTRL_RST;
		end else if (prot_ok) begin
			if (reg_addr == `PGB_ADDR_PG_CTRL) begin
				// Upper nibble not writable
				power_good_control_q <= reg_wdata & `PGB_PG_CTRL_WMASK;
			end else begin
				// Bit 6 and the code LSB keep their values
				buck_one_control_q <= (reg_wdata & `PGB_BUCK1_CTRL_WMASK)
					| (buck_one_control_q & ~`PGB_BUCK1_CTRL_WMASK);
			end
		end
	end

	// Read mux; unmapped addresses return zero
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`PGB_ADDR_UNLOCK_KEY: reg_rdata <= unlock_key_q;
				`PGB_ADDR_PG_CTRL:    reg_rdata <= power_good_control_q;
				`PGB_ADDR_BUCK1_CTRL: reg_rdata <= buck_one_control_q;
				default:              reg_rdata <= 8'h00;
			endcase
		end
	end

	/****************************************************************
	 * Power-good path
	 ****************************************************************/
	// Two-flop synchronisers for the analog status levels
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
		end else begin
			s1_q <= {other_good, linreg_two_good_status, linreg_one_good_status};
			s2_q <= s1_q;
		end
	end

	// Masked statuses count as good
	assign all_good = s2_q[2]
		&& (s2_q[0] || power_good_control_q[`PGB_PG_MASK_ONE_BIT])
		&& (s2_q[1] || power_good_control_q[`PGB_PG_MASK_TWO_BIT]);

	pgb_delay #(
		.CNT_W    (CNT_W),
		.DLY0_CYC (DLY0_CYC),
		.DLY1_CYC (DLY1_CYC),
		.DLY2_CYC (DLY2_CYC),
		.DLY3_CYC (DLY3_CYC)
	) u_delay (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.all_good (all_good),
		.dly_sel  (power_good_control_q[`PGB_PG_DLY_HI:`PGB_PG_DLY_LO]),
		.good_q   (delayed_good)
	);

	// Open drain: drive low while not good
	assign power_good_pin_o  = 1'b0;
	assign power_good_pin_oe = ~delayed_good;

	/****************************************************************
	 * Buck-one outputs
	 ****************************************************************/
	pgb_vcode u_vcode (
		.code (buck_one_control_q[`PGB_BUCK1_CODE_HI:`PGB_BUCK1_CODE_LO]),
		.mv   (mv)
	);

	// Registered converter controls
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			buck_one_external_adjust <= 1'b0;
			buck_one_voltage_code    <= 6'h00;
			buck_one_target_mv       <= 12'h000;
		end else begin
			buck_one_external_adjust <= buck_one_control_q[`PGB_BUCK1_EXT_BIT];
			buck_one_voltage_code    <= buck_one_control_q[`PGB_BUCK1_CODE_HI:`PGB_BUCK1_CODE_LO];
			buck_one_target_mv       <= mv;
		end
	end

endmodule

// [rtl/pgb_vcode.v]
/*
 * Decodes the buck-one voltage code into a target voltage in millivolts.
 * Purely combinational decode feeding a register in the parent.
 */
`timescale 1ns/1ps
`include "pgb_map.vh"

module pgb_vcode (
	input  wire [5:0]  code,
	output reg  [11:0] mv
);

	localparam [11:0] BASE_MV   = `PGB_V_BASE_MV;
	localparam [11:0] MID_MV    = `PGB_V_MID_MV;
	localparam [11:0] FINE_MV   = `PGB_V_FINE_STEP_MV;
	localparam [11:0] COARSE_MV = `PGB_V_COARSE_STEP_MV;
	localparam [11:0] MV_35     = `PGB_V_CODE_35_MV;
	localparam [11:0] MV_36     = `PGB_V_CODE_36_MV;
	localparam [11:0] MV_37     = `PGB_V_CODE_37_MV;
	localparam [11:0] TOP_MV    = `PGB_V_TOP_MV;

	reg [11:0] c12;

	// Two linear segments then four fixed top values; the step into
	// 3 V is 100 mV, so the coarse line must stop one code short
	always @* begin
		c12 = {6'h00, code};
		if (code <= `PGB_V_FINE_LAST) begin
			mv = BASE_MV + c12 * FINE_MV;
		end else if (code <= `PGB_V_COARSE_LAST) begin
			// Steps of 50 mV from 1.5 V up to 2.9 V
			mv = MID_MV + (c12 - {6'h00, `PGB_V_FINE_LAST}) * COARSE_MV;
		end else if (code == `PGB_V_CODE_35) begin
			mv = MV_35;
		end else if (code == `PGB_V_CODE_36) begin
			mv = MV_36;
		end else if (code == `PGB_V_CODE_37) begin
			mv = MV_37;
		end else begin
			mv = TOP_MV;
		end
	end

endmodule

// [testbench/pgb_regs_chk.sv]
/* Checker for pgb_regs: read-back fields, voltage decode, pin timing.
   Assumes it is bound into pgb_regs and sees only its ports. */
`timescale 1ns/1ps
module pgb_regs_chk #(
	parameter CNT_W = 27,
	parameter [CNT_W-1:0] DLY0_CYC = 1
) (
	input logic        clk_sys,
	input logic        sys_rst,
	input logic [7:0]  reg_addr,
	input logic        reg_rd,
	input logic [7:0]  reg_rdata,
	input logic        other_good,
	input logic        power_good_pin_o,
	input logic        power_good_pin_oe,
	input logic [5:0]  buck_one_voltage_code,
	input logic [11:0] buck_one_target_mv
);
	/********************
	 * Helpers
	 ********************/
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	int good_cnt_q;

	// Run of good cycles; sync flops make it longer, so a small slack
	always @(posedge clk_sys) begin
		if (sys_rst || !other_good)
			good_cnt_q <= 0;
		else
			good_cnt_q <= good_cnt_q + 1;
	end

	// Expected millivolts; 0x35 jumps 100 mV to land on 3 V
	function automatic logic [11:0] mv_of(input logic [5:0] c);
		if (c <= 6'h18) return 12'(900 + 25 * c);
		if (c <= 6'h34) return 12'(1500 + 50 * (c - 24));
		if (c == 6'h35) return 12'd3000;
		if (c == 6'h36) return 12'd3100;
		if (c == 6'h37) return 12'd3200;
		return 12'd3300;
	endfunction

	property p_pin_low; power_good_pin_o == 1'b0; endproperty
	property p_drop; $fell(other_good) |-> ##3 power_good_pin_oe; endproperty
	property p_hold; !other_good [*4] |-> power_good_pin_oe; endproperty
	property p_release; $fell(power_good_pin_oe) |-> good_cnt_q + 2 >= DLY0_CYC; endproperty
	property p_pg_rsvd; reg_rd && reg_addr == 8'h0d |=> reg_rdata[7:4] == 4'h0; endproperty
	property p_buck_rsvd; reg_rd && reg_addr == 8'h0e |=> reg_rdata[6] == 1'b0; endproperty
	property p_rd_lsb; reg_rd && reg_addr == 8'h0e |=> reg_rdata[0] == 1'b0; endproperty
	property p_code_lsb; buck_one_voltage_code[0] == 1'b0; endproperty
	property p_mv;
		!$past(sys_rst) && !$past(sys_rst, 2) |->
			buck_one_target_mv == mv_of(buck_one_voltage_code);
	endproperty

	a_pin_low: assert property (p_pin_low) else $error("pin drives high");
	a_drop: assert property (p_drop) else $error("pin late on drop");
	a_hold: assert property (p_hold) else $error("pin released while bad");
	a_release: assert property (p_release) else $error("pin released early");
	a_pg_rsvd: assert property (p_pg_rsvd) else $error("pg upper bits set");
	a_buck_rsvd: assert property (p_buck_rsvd) else $error("buck bit 6 set");
	a_rd_lsb: assert property (p_rd_lsb) else $error("buck lsb read set");
	a_code_lsb: assert property (p_code_lsb) else $error("code lsb set");
	a_mv: assert property (p_mv) else $error("voltage decode wrong");

	c_rel: cover property ($fell(power_good_pin_oe));
	c_rd: cover property (reg_rd && reg_addr == 8'h0e);
	c_bad: cover property ($fell(other_good));
endmodule

bind pgb_regs pgb_regs_chk #(.CNT_W(CNT_W), .DLY0_CYC(DLY0_CYC)) u_chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .other_good(other_good),
	.power_good_pin_o(power_good_pin_o), .power_good_pin_oe(power_good_pin_oe),
	.buck_one_voltage_code(buck_one_voltage_code),
	.buck_one_target_mv(buck_one_target_mv));

// [testbench/test_pgb_regs.sv]
/* Testbench for pgb_regs: reset values, unlock, decode and pin delay.
   Assumes short delay parameters and the checker bound alongside. */
`timescale 1ns/1ps
module test_pgb_regs;
	localparam int D[4] = '{20, 100, 200, 400};
	localparam logic [5:0] CV[7] = '{6'h00, 6'h02, 6'h18, 6'h1a, 6'h34, 6'h36, 6'h38};
	localparam int MV[7] = '{900, 950, 1500, 1600, 2900, 3100, 3300};
	logic        clk_sys = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, txn_end = 0;
	logic        l1 = 1, l2 = 1, og = 1, pin_o, pin_oe, ext;
	logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata, rd_v;
	logic [5:0]  code;
	logic [11:0] mv;
	int          err_count = 0, n_checks = 0, n;

	pgb_regs #(.CNT_W(12), .DLY0_CYC(12'd20), .DLY1_CYC(12'd100), .DLY2_CYC(12'd200),
		.DLY3_CYC(12'd400)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.txn_end(txn_end), .linreg_one_good_status(l1), .linreg_two_good_status(l2),
		.other_good(og), .power_good_pin_o(pin_o), .power_good_pin_oe(pin_oe),
		.buck_one_external_adjust(ext), .buck_one_voltage_code(code),
		.buck_one_target_mv(mv));

	/********************
	 * Bus tasks
	 ********************/
	initial forever #2.5 clk_sys = ~clk_sys;

	task automatic chk(input string nm, input logic [11:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	// Every write is its own transaction, closed by a stop pulse
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk_sys);
		reg_wr <= 0;
		txn_end <= 1;
		@(posedge clk_sys);
		txn_end <= 0;
	endtask
	task automatic pw(input logic [7:0] a, d);
		wr(8'h0b, 8'h7d);
		wr(a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk_sys);
		reg_rd <= 0;
		#1 rd_v = reg_rdata;
	endtask

	/********************
	 * Scenarios
	 ********************/
	task automatic t_reset;
		cyc(1);
		chk("oe_rst", pin_oe, 1);
		rd(8'h0d);
		chk("pg_rst", rd_v, 8'h0c);
		rd(8'h0e);
		chk("buck_rst", rd_v, 8'h18);
		chk("ext_rst", ext, 0);
		chk("mv_rst", mv, 12'd1500);
		cyc(40);
		chk("oe_rel", pin_oe, 0);
	endtask
	// Wrong key, no key, and a key spent by an intervening transaction
	task automatic t_lock;
		wr(8'h0e, 8'hff);
		wr(8'h0b, 8'h7c);
		wr(8'h0d, 8'h00);
		wr(8'h0b, 8'h7d);
		wr(8'h20, 8'h55);
		wr(8'h0e, 8'h80);
		rd(8'h0e);
		chk("lock_b", rd_v, 8'h18);
		rd(8'h0d);
		chk("lock_p", rd_v, 8'h0c);
		rd(8'h0b);
		chk("key_clr", rd_v, 8'h00);
		rd(8'h20);
		chk("unmapped", rd_v, 8'h00);
	endtask
	task automatic t_buck;
		pw(8'h0e, 8'hff);
		wr(8'h0e, 8'h00);
		rd(8'h0e);
		chk("buck_wr", rd_v, 8'hbe);
		chk("ext_on", ext, 1);
		for (int i = 0; i < 7; i++) begin
			pw(8'h0e, {2'b00, CV[i]} | 8'h01);
			cyc(2);
			chk("code", code, CV[i]);
			chk("mv", mv, 12'(MV[i]));
			chk("ext_off", ext, 0);
		end
	endtask
	// Each delay setting, alternating which regulator is unmasked
	task automatic t_pg;
		pw(8'h0d, 8'hf3);
		rd(8'h0d);
		chk("pg_rsvd", rd_v, 8'h03);
		for (int i = 0; i < 4; i++) begin
			pw(8'h0d, (i[0] ? 8'h08 : 8'h04) | 8'(i));
			if (i[0]) l2 <= 0;
			else l1 <= 0;
			cyc(4);
			chk("oe_drop", pin_oe, 1);
			@(posedge clk_sys);
			l1 <= 1;
			l2 <= 1;
			n = 0;
			while (pin_oe !== 1'b0 && n < 1000) begin
				cyc(1);
				n++;
			end
			chk("delay", 12'(n >= D[i] && n <= D[i] + 6), 1);
		end
		pw(8'h0d, 8'h0c);
		l1 <= 0;
		l2 <= 0;
		cyc(8);
		chk("masked", pin_oe, 0);
		@(posedge clk_sys);
		og <= 0;
		cyc(5);
		chk("other", pin_oe, 1);
		@(posedge clk_sys);
		og <= 1;
		l1 <= 1;
		l2 <= 1;
		cyc(40);
		chk("rel0", pin_oe, 0);
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 0;
		t_reset();
		t_lock();
		t_buck();
		t_pg();
		test_done();
	end
	// Whole run needs about 1000 cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		test_done();
	end
endmodule
